// file: rtl/eadi_map.svh
// register offsets, field positions, reset values and timing values in ns
`ifndef EADI_MAP_SVH
`define EADI_MAP_SVH
`define EADI_OFF_CTRL 8'h00
`define EADI_OFF_STATUS 8'h04
`define EADI_OFF_TX_VLAN 8'h08
`define EADI_OFF_TX_ID 8'h0C
`define EADI_OFF_TX_DELAY 8'h10
`define EADI_OFF_TX_OFFSET 8'h14
`define EADI_OFF_TX_INTERVAL 8'h18
`define EADI_OFF_RX_VLAN 8'h1C
`define EADI_OFF_RX_DELAY 8'h20
`define EADI_OFF_AN_VLAN 8'h24
`define EADI_OFF_AN_IP 8'h28
`define EADI_OFF_AN_UDP 8'h2C
`define EADI_OFF_TX_APPID 8'h30
`define EADI_OFF_SRC_COUNT 8'h34
`define EADI_OFF_SNK_COUNT 8'h38
`define EADI_BIT_ENABLE 0
`define EADI_BIT_EXT 1
`define EADI_BIT_TX_EN 2
`define EADI_BIT_TX_STAT 3
`define EADI_BIT_TX_VSEL 4
`define EADI_BIT_TX_REG 5
`define EADI_BIT_RX_EN 6
`define EADI_BIT_RX_VSEL 7
`define EADI_BIT_RX_VIGN 8
`define EADI_BIT_AN_EN 9
`define EADI_BIT_AN_VSEL 10
`define EADI_BIT_AN_VIGN 11
`define EADI_RST_WORD 32'h0000_0000
`define EADI_CLK_PERIOD_NS 20
`define EADI_TX_WAIT_NS 1000
`define EADI_RX_WAIT_NS 100
`endif

// file: rtl/eadi_pkg.sv
// types of the external payload ports and the configuration/status vectors
package eadi_pkg;
  typedef struct packed {
    logic [31:0] second;
    logic [31:0] nanosecond;
    logic [1:0] fraction;
    logic sign;
    logic time_jump;
  } eadi_time_type;

  typedef struct packed {
    logic [7:0] app_id;
    logic [255:0] app_data;
    logic [7:0] data_length;
    logic payload_valid_flag;
    logic [15:0] seq_nr;
    logic [63:0] stamp;
  } eadi_source_type;

  typedef struct packed {
    logic [7:0] app_id;
    logic [255:0] app_data;
    logic [7:0] data_length;
    logic payload_valid_flag;
    logic [15:0] seq_nr;
    logic [63:0] stamp;
    logic [15:0] talker_id;
  } eadi_sink_type;

  typedef struct packed {
    logic enable;
    logic tx_stats_clear_request;
    logic tx_vlan_source_select;
    logic [15:0] vlan;
    logic [47:0] mac;
    logic [15:0] id;
    logic [31:0] delay;
    logic [31:0] offset;
    logic [31:0] interval;
    logic app_reg;
    logic [7:0] app_id;
    logic [255:0] app_data;
  } eadi_tx_cfg_type;

  typedef struct packed {
    logic enable;
    logic vlan_sel;
    logic rx_vlan_ignore;
    logic [15:0] vlan;
    logic [31:0] rx_cable_delay;
  } eadi_rx_cfg_type;

  typedef struct packed {
    logic enable;
    logic vlan_sel;
    logic vlan_ignore;
    logic [15:0] vlan;
    logic [31:0] ip;
    logic [15:0] analysis_udp_port;
  } eadi_an_cfg_type;

  typedef struct packed {
    logic enable;
    logic external_payload_select;
    eadi_tx_cfg_type tx;
    eadi_rx_cfg_type rx;
    eadi_an_cfg_type an;
  } eadi_cfg_type;

  typedef struct packed {
    logic tx_enabled;
    logic tx_error;
    logic tx_sending;
    logic rx_enabled;
    logic rx_error;
    logic rx_receiving;
    logic an_enabled;
    logic an_error;
    logic led_enabled;
    logic led_error;
    logic [7:0] led0;
    logic [7:0] led1;
    logic [7:0] led2;
    logic [14:0] curtain_state;
  } eadi_sub_status_type;

  typedef struct packed {
    logic enabled;
    logic ext_in_use;
    eadi_sub_status_type sub;
  } eadi_status_type;
endpackage

// file: rtl/eadi_top.sv
// external application data interface with configuration and status
// Function
// - event mode: payload valid only in the strobe cycle.
// - event mode: receiver consumes payload in the strobe cycle only.
// - event mode: sender holds payload while strobe is high.
// - buffered mode: payload always valid; strobe marks fresh payload.
// - buffered mode: receiver uses payload from strobe until next strobe.
// - buffered mode: payload flags not-valid from reset until first delivery.
// - buffered mode: sender changes payload only with the strobe.
// - a boolean parameter selects buffered (true) or event (false) mode.
// - clock period parameter in whole ns, default 20.
// - each subunit exists only when its presence parameter is true.
// - source and sink ports exist only when their parameter is set; here they always exist and carry no traffic when not set.
// - internal timestamping option exists but is not for use.
// - transmitter stamp wait bounded by parameter, shorter than interval.
// - maker text 32 chars, part text 10 chars, space padded.
// - time: 32-bit seconds, 32-bit ns, 2-bit fraction, sign, jump.
// - transmitter configuration fields as listed.
// - statistics-clear bit marks outgoing frames to clear remote stats.
// - receiver configuration fields as listed.
// - analyzer configuration fields as listed.
// - top configuration: global enable, external select, subunit groups.
// - status reports enabled/error per subunit, busy for transmitter and receiver only, and global flags.
// - LED status: enabled, error, three brightness bytes, 15-bit curtain.
// - the valid strobe lasts exactly one clock cycle.
// - ports run on the core system clock.
`timescale 1ns/10ps
`include "eadi_map.svh"
module eadi_top #(
  parameter bit ext_port_handshake_select = 1'b0,
  parameter int sys_clock_period_ns = `EADI_CLK_PERIOD_NS,
  parameter bit transmitter_present = 1'b1,
  parameter bit receiver_present = 1'b1,
  parameter bit analyzer_present = 1'b1,
  parameter bit led_brightness_present = 1'b0,
  parameter bit led_pattern_present = 1'b0,
  parameter bit register_payload_present = 1'b1,
  parameter bit ext_source_present = 1'b1,
  parameter bit ext_sink_present = 1'b1,
  parameter bit internal_stamping_option = 1'b0,
  parameter int tx_stamp_wait_ns = `EADI_TX_WAIT_NS,
  parameter int rx_stamp_wait_ns = `EADI_RX_WAIT_NS,
  // arbitrary neutral texts, space padded
  parameter logic [255:0] maker_text = {"generic maker", {19{" "}}},
  parameter logic [79:0] part_text = {"core", {6{" "}}}
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // external source from custom application
  input wire logic src_valid_i,
  input wire eadi_pkg::eadi_source_type src_data_i,
  // payload towards the transmitter
  output logic tx_valid_o,
  output eadi_pkg::eadi_source_type tx_data_o,
  // received payload from the receiver
  input wire logic rx_valid_i,
  input wire eadi_pkg::eadi_sink_type rx_data_i,
  // external sink towards custom application
  output logic snk_valid_o,
  output eadi_pkg::eadi_sink_type snk_data_o,
  // subunit status in, configuration out
  input wire eadi_pkg::eadi_sub_status_type sub_status_i,
  input wire logic tx_stamp_ack_i,
  output eadi_pkg::eadi_cfg_type cfg_o,
  output eadi_pkg::eadi_status_type status_o,
  output logic tx_stamp_timeout_o,
  output logic rx_stamp_timeout_o,
  output logic tx_stats_mark_o
);
  // wait counts derived from ns and clock period, rounded down
  localparam int TX_WAIT_CYC = (tx_stamp_wait_ns / sys_clock_period_ns) < 1
    ? 1 : tx_stamp_wait_ns / sys_clock_period_ns;
  localparam int RX_WAIT_CYC = (rx_stamp_wait_ns / sys_clock_period_ns) < 1
    ? 1 : rx_stamp_wait_ns / sys_clock_period_ns;

  eadi_pkg::eadi_cfg_type cfg_reg;
  logic rd_ack_reg;
  logic [31:0] src_cnt_reg;
  logic [31:0] snk_cnt_reg;
  logic [31:0] tx_wait_reg;
  logic [31:0] rx_wait_reg;
  logic tx_busy_reg;
  logic rx_busy_reg;
  logic [31:0] rd_next;
  logic [31:0] ctrl_word;
  logic [31:0] wr_word;
  logic wr;
  logic src_ok;
  logic snk_ok;

  // ports that are not present never see traffic
  assign src_ok = ext_source_present && transmitter_present &&
    cfg_reg.external_payload_select && cfg_reg.enable;
  assign snk_ok = ext_sink_present && receiver_present &&
    cfg_reg.external_payload_select && cfg_reg.enable;
  assign wr = avs_write_i;

  // writes complete at once, reads one cycle later
  assign avs_waitrequest_o = avs_read_i && !rd_ack_reg;

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign ctrl_word = {20'h0_0000, cfg_reg.an.vlan_ignore, cfg_reg.an.vlan_sel,
    cfg_reg.an.enable, cfg_reg.rx.rx_vlan_ignore, cfg_reg.rx.vlan_sel,
    cfg_reg.rx.enable, cfg_reg.tx.app_reg, cfg_reg.tx.tx_vlan_source_select,
    cfg_reg.tx.tx_stats_clear_request, cfg_reg.tx.enable,
    cfg_reg.external_payload_select, cfg_reg.enable};
  // lanes merged over the addressed register's current contents
  assign wr_word = merge(rd_next, avs_writedata_i, avs_byteenable_i);

  // configuration register file
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg <= '0;
    end else if (wr) begin
      case (avs_address_i)
        `EADI_OFF_CTRL: begin
          cfg_reg.enable <= wr_word[`EADI_BIT_ENABLE];
          cfg_reg.external_payload_select <= wr_word[`EADI_BIT_EXT] &&
            (ext_source_present || ext_sink_present);
          cfg_reg.tx.enable <= wr_word[`EADI_BIT_TX_EN] && transmitter_present;
          cfg_reg.tx.tx_stats_clear_request <= wr_word[`EADI_BIT_TX_STAT];
          cfg_reg.tx.tx_vlan_source_select <= wr_word[`EADI_BIT_TX_VSEL];
          cfg_reg.tx.app_reg <= wr_word[`EADI_BIT_TX_REG] &&
            register_payload_present;
          cfg_reg.rx.enable <= wr_word[`EADI_BIT_RX_EN] && receiver_present;
          cfg_reg.rx.vlan_sel <= wr_word[`EADI_BIT_RX_VSEL];
          cfg_reg.rx.rx_vlan_ignore <= wr_word[`EADI_BIT_RX_VIGN];
          cfg_reg.an.enable <= wr_word[`EADI_BIT_AN_EN] && analyzer_present;
          cfg_reg.an.vlan_sel <= wr_word[`EADI_BIT_AN_VSEL];
          cfg_reg.an.vlan_ignore <= wr_word[`EADI_BIT_AN_VIGN];
        end
        `EADI_OFF_TX_VLAN:
          cfg_reg.tx.vlan <= wr_word[15:0];
        `EADI_OFF_TX_ID:
          cfg_reg.tx.id <= wr_word[15:0];
        `EADI_OFF_TX_DELAY:
          cfg_reg.tx.delay <= wr_word;
        `EADI_OFF_TX_OFFSET:
          cfg_reg.tx.offset <= wr_word;
        `EADI_OFF_TX_INTERVAL:
          cfg_reg.tx.interval <= wr_word;
        `EADI_OFF_RX_VLAN:
          cfg_reg.rx.vlan <= wr_word[15:0];
        `EADI_OFF_RX_DELAY:
          cfg_reg.rx.rx_cable_delay <= wr_word;
        `EADI_OFF_AN_VLAN:
          cfg_reg.an.vlan <= wr_word[15:0];
        `EADI_OFF_AN_IP:
          cfg_reg.an.ip <= wr_word;
        `EADI_OFF_AN_UDP:
          cfg_reg.an.analysis_udp_port <= wr_word[15:0];
        `EADI_OFF_TX_APPID:
          cfg_reg.tx.app_id <= wr_word[7:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (avs_address_i)
      `EADI_OFF_CTRL: rd_next = ctrl_word;
      `EADI_OFF_STATUS: rd_next = {18'h0_0000, status_o.enabled,
        status_o.ext_in_use, tx_busy_reg, rx_busy_reg,
        status_o.sub.led_error, status_o.sub.led_enabled,
        status_o.sub.an_error, status_o.sub.an_enabled,
        status_o.sub.rx_receiving, status_o.sub.rx_error,
        status_o.sub.rx_enabled, status_o.sub.tx_sending,
        status_o.sub.tx_error, status_o.sub.tx_enabled};
      `EADI_OFF_TX_VLAN: rd_next = {16'h0000, cfg_reg.tx.vlan};
      `EADI_OFF_TX_ID: rd_next = {16'h0000, cfg_reg.tx.id};
      `EADI_OFF_TX_DELAY: rd_next = cfg_reg.tx.delay;
      `EADI_OFF_TX_OFFSET: rd_next = cfg_reg.tx.offset;
      `EADI_OFF_TX_INTERVAL: rd_next = cfg_reg.tx.interval;
      `EADI_OFF_RX_VLAN: rd_next = {16'h0000, cfg_reg.rx.vlan};
      `EADI_OFF_RX_DELAY: rd_next = cfg_reg.rx.rx_cable_delay;
      `EADI_OFF_AN_VLAN: rd_next = {16'h0000, cfg_reg.an.vlan};
      `EADI_OFF_AN_IP: rd_next = cfg_reg.an.ip;
      `EADI_OFF_AN_UDP: rd_next = {16'h0000, cfg_reg.an.analysis_udp_port};
      `EADI_OFF_TX_APPID: rd_next = {24'h00_0000, cfg_reg.tx.app_id};
      `EADI_OFF_SRC_COUNT: rd_next = src_cnt_reg;
      `EADI_OFF_SNK_COUNT: rd_next = snk_cnt_reg;
      default: rd_next = `EADI_RST_WORD;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ack_reg <= 1'b0;
      avs_readdata_o <= '0;
    end else begin
      rd_ack_reg <= avs_read_i && !rd_ack_reg;
      if (avs_read_i && !rd_ack_reg) begin
        avs_readdata_o <= rd_next;
      end
    end
  end

  // transmit path: source to transmitter, registered once
  // everything on clk_i, no interface clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= '0; // valid flag low until first delivery
      src_cnt_reg <= '0;
    end else begin
      tx_valid_o <= src_ok && src_valid_i;
      if (src_ok && src_valid_i) begin
        tx_data_o <= src_data_i;
        src_cnt_reg <= src_cnt_reg + 32'h0000_0001;
      end else if (!ext_port_handshake_select) begin
        // event mode: hide payload outside the strobe cycle
        tx_data_o.payload_valid_flag <= 1'b0;
      end
      // buffered mode keeps the last payload standing
    end
  end

  // receive path: receiver to sink
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      snk_valid_o <= 1'b0;
      snk_data_o <= '0;
      snk_cnt_reg <= '0;
    end else begin
      snk_valid_o <= snk_ok && rx_valid_i;
      if (snk_ok && rx_valid_i) begin
        snk_data_o <= rx_data_i;
        snk_cnt_reg <= snk_cnt_reg + 32'h0000_0001;
      end else if (!ext_port_handshake_select) begin
        snk_data_o.payload_valid_flag <= 1'b0;
      end
    end
  end

  // stamp wait supervision; internal stamping is not supported
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_busy_reg <= 1'b0;
      tx_wait_reg <= '0;
      tx_stamp_timeout_o <= 1'b0;
    end else begin
      tx_stamp_timeout_o <= 1'b0;
      if (tx_valid_o && cfg_reg.tx.enable) begin
        tx_busy_reg <= 1'b1;
        tx_wait_reg <= '0;
      end else if (tx_busy_reg) begin
        if (tx_stamp_ack_i) begin
          tx_busy_reg <= 1'b0;
        end else if (tx_wait_reg == 32'(TX_WAIT_CYC - 1)) begin
          tx_busy_reg <= 1'b0;
          tx_stamp_timeout_o <= 1'b1;
        end else begin
          tx_wait_reg <= tx_wait_reg + 32'h0000_0001;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_busy_reg <= 1'b0;
      rx_wait_reg <= '0;
      rx_stamp_timeout_o <= 1'b0;
    end else begin
      rx_stamp_timeout_o <= 1'b0;
      if (rx_valid_i && cfg_reg.rx.enable) begin
        rx_busy_reg <= 1'b1;
        rx_wait_reg <= '0;
      end else if (rx_busy_reg) begin
        if (rx_wait_reg == 32'(RX_WAIT_CYC - 1)) begin
          rx_busy_reg <= 1'b0;
          rx_stamp_timeout_o <= 1'b1;
        end else begin
          rx_wait_reg <= rx_wait_reg + 32'h0000_0001;
        end
      end
    end
  end

  // status vector; absent subunits report zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_o <= '0;
      cfg_o <= '0;
      tx_stats_mark_o <= 1'b0;
    end else begin
      cfg_o <= cfg_reg;
      tx_stats_mark_o <= cfg_reg.tx.enable &&
        cfg_reg.tx.tx_stats_clear_request;
      status_o.enabled <= cfg_reg.enable;
      status_o.ext_in_use <= cfg_reg.enable &&
        cfg_reg.external_payload_select;
      status_o.sub <= sub_status_i;
      if (!transmitter_present) begin
        status_o.sub.tx_enabled <= 1'b0;
        status_o.sub.tx_error <= 1'b0;
        status_o.sub.tx_sending <= 1'b0;
      end
      if (!receiver_present) begin
        status_o.sub.rx_enabled <= 1'b0;
        status_o.sub.rx_error <= 1'b0;
        status_o.sub.rx_receiving <= 1'b0;
      end
      if (!analyzer_present) begin
        status_o.sub.an_enabled <= 1'b0;
        status_o.sub.an_error <= 1'b0;
      end
      if (!(led_brightness_present || led_pattern_present)) begin
        status_o.sub.led_enabled <= 1'b0;
        status_o.sub.led_error <= 1'b0;
        status_o.sub.led0 <= 8'h00;
        status_o.sub.led1 <= 8'h00;
        status_o.sub.led2 <= 8'h00;
        status_o.sub.curtain_state <= 15'h0000;
      end
    end
  end
endmodule

// file: tb/eadi_top_monitor.sv
// concurrent checks on the payload ports and register bus of eadi_top
`timescale 1ns/10ps
`include "eadi_map.svh"
module eadi_top_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  // payload ports and configuration
  input wire logic src_valid_i,
  input wire eadi_pkg::eadi_source_type src_data_i,
  input wire logic tx_valid_o,
  input wire eadi_pkg::eadi_source_type tx_data_o,
  input wire logic rx_valid_i,
  input wire eadi_pkg::eadi_sink_type rx_data_i,
  input wire logic snk_valid_o,
  input wire eadi_pkg::eadi_sink_type snk_data_o,
  input wire eadi_pkg::eadi_cfg_type cfg_o,
  input wire logic tx_stamp_timeout_o,
  input wire logic rx_stamp_timeout_o,
  input wire logic tx_stats_mark_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence rd_start; $rose(avs_read_i); endsequence
  sequence rd_done; !avs_waitrequest_o; endsequence
  sequence ext_on; cfg_o.enable && cfg_o.external_payload_select; endsequence
  sequence stats_on;
    (cfg_o.tx.enable && cfg_o.tx.tx_stats_clear_request) [*3];
  endsequence

  a_read_two_cycles: assert property (
    rd_start |-> avs_waitrequest_o ##1 rd_done)
    else $error("read answer not on second cycle");
  a_write_no_wait: assert property (
    avs_write_i |-> !avs_waitrequest_o)
    else $error("write stalled");
  a_src_pass_on: assert property (
    src_valid_i ##1 ext_on |-> tx_valid_o && tx_data_o == $past(src_data_i))
    else $error("source payload not passed");
  a_src_refused: assert property (
    src_valid_i ##1 !(cfg_o.enable && cfg_o.external_payload_select) |->
      !tx_valid_o)
    else $error("payload passed while disabled");
  a_tx_strobe_cause: assert property (
    tx_valid_o |-> $past(src_valid_i))
    else $error("transmit strobe without source strobe");
  a_tx_flag_event: assert property (
    !tx_valid_o |-> !tx_data_o.payload_valid_flag)
    else $error("payload flagged valid outside strobe");
  a_snk_pass_on: assert property (
    rx_valid_i ##1 ext_on |-> snk_valid_o && snk_data_o == $past(rx_data_i))
    else $error("received payload not passed");
  a_snk_flag_event: assert property (
    !snk_valid_o |-> !snk_data_o.payload_valid_flag)
    else $error("sink payload flagged valid outside strobe");
  a_cfg_copy_delay: assert property (
    avs_write_i && avs_address_i == `EADI_OFF_RX_DELAY &&
    avs_byteenable_i == 4'hF |->
    ##2 cfg_o.rx.rx_cable_delay == $past(avs_writedata_i, 2))
    else $error("receive delay not in configuration");
  a_stats_mark_on: assert property (
    stats_on |-> tx_stats_mark_o)
    else $error("statistics mark missing");
  a_tx_timeout_pulse: assert property (
    tx_stamp_timeout_o |=> !tx_stamp_timeout_o)
    else $error("transmit timeout longer than one cycle");
  a_rx_timeout_pulse: assert property (
    rx_stamp_timeout_o |=> !rx_stamp_timeout_o)
    else $error("receive timeout longer than one cycle");
endmodule

bind eadi_top eadi_top_monitor mon (.clk_i, .rst_n_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_waitrequest_o, .src_valid_i, .src_data_i, .tx_valid_o, .tx_data_o,
  .rx_valid_i, .rx_data_i, .snk_valid_o, .snk_data_o, .cfg_o,
  .tx_stamp_timeout_o, .rx_stamp_timeout_o, .tx_stats_mark_o);

// file: tb/eadi_app_model.sv
// custom application model: payload source and payload sink
`timescale 1ns/10ps
module eadi_app_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // source side
  input wire logic send_i,
  output eadi_pkg::eadi_source_type src_data_o,
  output logic src_valid_o,
  // sink side
  input wire logic snk_valid_i,
  input wire eadi_pkg::eadi_sink_type snk_data_i,
  output eadi_pkg::eadi_sink_type got_o,
  output logic [15:0] got_cnt_o
);
  logic [15:0] seq_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_reg <= 16'h0000;
      src_valid_o <= 1'b0;
      src_data_o <= '0;
    end else if (send_i) begin
      seq_reg <= seq_reg + 16'h0001;
      src_valid_o <= 1'b1;
      src_data_o <= {8'hA5, {16{seq_reg}}, 8'h20, 1'b1, seq_reg,
        48'h0000_0000_0000, seq_reg};
    end else begin
      src_valid_o <= 1'b0;
      // junk between strobes, so a sink that peeks outside them fails
      src_data_o <= ~src_data_o;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      got_o <= '0;
      got_cnt_o <= 16'h0000;
    end else if (snk_valid_i) begin
      got_o <= snk_data_i;
      got_cnt_o <= got_cnt_o + 16'h0001;
    end
  end
endmodule

// file: tb/tb_ext_app_data_interface.sv
// self-checking bench for the external application data interface
`timescale 1ns/10ps
module tb_ext_app_data_interface;
  logic clk_i;
  logic rst_n_i;
  logic [7:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic send;
  logic src_valid;
  eadi_pkg::eadi_source_type src_data;
  logic tx_valid_o;
  eadi_pkg::eadi_source_type tx_data_o;
  logic rx_valid_i;
  eadi_pkg::eadi_sink_type rx_data_i;
  logic snk_valid_o;
  eadi_pkg::eadi_sink_type snk_data_o;
  eadi_pkg::eadi_sub_status_type sub_status_i;
  logic tx_stamp_ack_i;
  eadi_pkg::eadi_cfg_type cfg_o;
  eadi_pkg::eadi_status_type status_o;
  logic tx_stamp_timeout_o;
  logic rx_stamp_timeout_o;
  logic tx_stats_mark_o;
  eadi_pkg::eadi_sink_type got;
  logic [15:0] got_cnt;
  logic [15:0] last_seq;
  logic [31:0] q;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_tx = 0;
  int n_tto = 0;
  int n_rto = 0;
  // address and read-back after writing all ones
  logic [7:0] ra [14] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
    8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h3C};
  logic [31:0] rm [14] = '{32'h0000_0FFF, 32'h0000_FFFF, 32'h0000_FFFF,
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF,
    32'hFFFF_FFFF, 32'h0000_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF,
    32'h0000_00FF, 32'h0000_0000, 32'h0000_0000};

  // shorter period so the stamp waits fit the run: 200 and 20 cycles
  eadi_top #(.sys_clock_period_ns(5)) dut (.clk_i, .rst_n_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .src_valid_i(src_valid), .src_data_i(src_data), .tx_valid_o,
    .tx_data_o, .rx_valid_i, .rx_data_i, .snk_valid_o, .snk_data_o,
    .sub_status_i, .tx_stamp_ack_i, .cfg_o, .status_o,
    .tx_stamp_timeout_o, .rx_stamp_timeout_o, .tx_stats_mark_o);

  eadi_app_model app (.clk_i, .rst_n_i, .send_i(send),
    .src_data_o(src_data), .src_valid_o(src_valid),
    .snk_valid_i(snk_valid_o), .snk_data_i(snk_data_o), .got_o(got),
    .got_cnt_o(got_cnt));

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got_v);
    n_checks++;
    if (got_v !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got_v);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] b, output logic [31:0] r);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= b;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    r = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // one-cycle strobes with a gap between them, never a held strobe
  task automatic pulse_send(input int n);
    repeat (n) begin
      send <= 1'b1;
      @(posedge clk_i);
      send <= 1'b0;
      @(posedge clk_i);
    end
    repeat (5) @(posedge clk_i);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (tx_valid_o === 1'b1) begin
      n_tx <= n_tx + 1;
      last_seq <= tx_data_o.seq_nr;
    end
    if (tx_stamp_timeout_o === 1'b1) n_tto <= n_tto + 1;
    if (rx_stamp_timeout_o === 1'b1) n_rto <= n_rto + 1;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    rst_n_i = 1'b0;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'h0;
    send = 1'b0;
    rx_valid_i = 1'b0;
    rx_data_i = '0;
    tx_stamp_ack_i = 1'b0;
    sub_status_i = '0;
    sub_status_i.tx_enabled = 1'b1;
    sub_status_i.rx_error = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 14; i++) begin
      bus(1'b0, ra[i], 32'h0000_0000, 4'hF, q);
      chk("reset value", 32'h0000_0000, q);
      bus(1'b1, ra[i], 32'hFFFF_FFFF, 4'hF, q);
      bus(1'b0, ra[i], 32'h0000_0000, 4'hF, q);
      chk("read back", rm[i], q);
    end
    chk("rx delay cfg", 32'hFFFF_FFFF, cfg_o.rx.rx_cable_delay);
    chk("udp cfg", 32'h0000_FFFF, 32'(cfg_o.an.analysis_udp_port));
    chk("interval cfg", 32'hFFFF_FFFF, cfg_o.tx.interval);
    bus(1'b1, 8'h10, 32'h1122_3344, 4'h1, q);
    bus(1'b0, 8'h10, 32'h0000_0000, 4'hF, q);
    chk("lane merge", 32'hFFFF_FF44, q);
    bus(1'b1, 8'h00, 32'h0000_000C, 4'hF, q);
    repeat (3) @(posedge clk_i);
    chk("stats mark", 32'h0000_0001, 32'(tx_stats_mark_o));
    bus(1'b1, 8'h00, 32'h0000_0008, 4'hF, q);
    repeat (3) @(posedge clk_i);
    chk("stats mark off", 32'h0000_0000, 32'(tx_stats_mark_o));
    bus(1'b0, 8'h04, 32'h0000_0000, 4'hF, q);
    chk("status word", 32'h0000_0011, q & 32'h0000_03FF);
    bus(1'b1, 8'h00, 32'h0000_0003, 4'hF, q);
    repeat (2) @(posedge clk_i);
    chk("global enabled", 32'h0000_0001, 32'(status_o.enabled));
    pulse_send(3);
    chk("strobes passed", 32'h0000_0003, 32'(n_tx));
    chk("last sequence", 32'h0000_0002, 32'(last_seq));
    rx_data_i.talker_id <= 16'h00AB;
    rx_valid_i <= 1'b1;
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    rx_data_i.talker_id <= 16'h5454;
    repeat (3) @(posedge clk_i);
    chk("sink talker", 32'h0000_00AB, 32'(got.talker_id));
    chk("sink strobes", 32'h0000_0001, 32'(got_cnt));
    bus(1'b0, 8'h34, 32'h0000_0000, 4'hF, q);
    chk("source count", 32'h0000_0003, q);
    bus(1'b0, 8'h38, 32'h0000_0000, 4'hF, q);
    chk("sink count", 32'h0000_0001, q);
    bus(1'b1, 8'h00, 32'h0000_0001, 4'hF, q);
    pulse_send(1);
    chk("refused strobe", 32'h0000_0003, 32'(n_tx));
    bus(1'b1, 8'h00, 32'h0000_0047, 4'hF, q);
    pulse_send(1);
    tx_stamp_ack_i <= 1'b1;
    @(posedge clk_i);
    tx_stamp_ack_i <= 1'b0;
    repeat (250) @(posedge clk_i);
    chk("acked no timeout", 32'h0000_0000, 32'(n_tto));
    sub_status_i.rx_receiving <= 1'b1;
    pulse_send(1);
    rx_valid_i <= 1'b1;
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    repeat (300) @(posedge clk_i);
    chk("tx stamp timeout", 32'h0000_0001, 32'(n_tto != 0));
    chk("rx stamp timeout", 32'h0000_0001, 32'(n_rto != 0));
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("cfg in reset", 32'h0000_0000, 32'(cfg_o.enable));
    chk("status in reset", 32'h0000_0000, 32'(status_o.enabled));
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    bus(1'b0, 8'h00, 32'h0000_0000, 4'hF, q);
    chk("ctrl after reset", 32'h0000_0000, q);
    print_verdict();
  end
endmodule
